// ---- rtl/mcr_params.svh ----
// offsets, field positions, reset values and timing counts of the motor control register bank
`ifndef MCR_PARAMS_SVH
`define MCR_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets (word index on the register port)
// ----------------------------------------------------------------
`define MCR_OFF_POS_WRITE 5'h00
`define MCR_OFF_WRAP_LIMIT 5'h01
`define MCR_OFF_INDEX_PRELOAD 5'h02
`define MCR_OFF_ENC_CTRL 5'h03
`define MCR_OFF_GATE_CFG 5'h04
`define MCR_OFF_CARRIER_PERIOD 5'h05
`define MCR_OFF_DEAD_TIME 5'h06
`define MCR_OFF_SYS_CTRL 5'h07
`define MCR_OFF_D_REF 5'h08
`define MCR_OFF_Q_REF 5'h09
`define MCR_OFF_VEL_SCALE 5'h0A
`define MCR_OFF_MOD_SCALE 5'h0B
`define MCR_OFF_FAULT_CTRL 5'h0C
`define MCR_OFF_POS_COUNT 5'h10
`define MCR_OFF_STATUS 5'h11
`define MCR_OFF_IRQ_STATUS 5'h12
`define MCR_OFF_IRQ_MASK 5'h13

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MCR_ENC_INDEX_LOAD_BIT 0
`define MCR_ENC_COUNT_ENABLE_BIT 1
`define MCR_GATE_TRIP_POL_BIT 0
`define MCR_GATE_LOW_POL_BIT 1
`define MCR_GATE_HIGH_POL_BIT 2
`define MCR_GATE_SHUTDOWN_BIT 3
`define MCR_GATE_ALIGN_BIT 4
`define MCR_SYS_BUS_COMP_BIT 0
`define MCR_SYS_OFFSET_BIT 1
`define MCR_SYS_VECTOR_BIT 2
`define MCR_SYS_GATE_EN_BIT 3
`define MCR_FLT_CLEAR_BIT 0
`define MCR_FLT_MONITOR_BIT 1
`define MCR_IRQ_WRAP_BIT 0
`define MCR_IRQ_INDEX_BIT 1
`define MCR_IRQ_TRIP_BIT 2

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define MCR_RESET_WORD 16'h0000
`define MCR_DEAD_TICK_PS 30000
`define MCR_CLK_PERIOD_PS 10000
// one dead-time tick in clock cycles, rounded up
`define MCR_DEAD_TICK_CYCLES ((`MCR_DEAD_TICK_PS + `MCR_CLK_PERIOD_PS - 1) / `MCR_CLK_PERIOD_PS)

`endif

// ---- rtl/mcr_pkg.sv ----
// types shared by the motor control register bank
package mcr_pkg;

   // ----------------------------------------------------------------
   // register port request
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [4:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } mcr_req_t;

   // gate outputs of one phase leg
   typedef struct packed {
      logic high;
      logic low;
   } mcr_leg_t;

   typedef enum logic [1:0] {MCR_LEG_OFF, MCR_LEG_DEAD, MCR_LEG_ON} mcr_dead_state_t;

endpackage : mcr_pkg

// ---- rtl/mcr_regs.sv ----
// host control and status register bank with encoder counter, gate polarity and dead time
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`include "mcr_params.svh"

module mcr_regs
(
   input wire logic clk,
   input wire logic reset_n,
   input wire mcr_pkg::mcr_req_t req,
   output logic [15:0] rdata,
   input wire logic count_pulse,
   input wire logic count_down,
   input wire logic index_pulse,
   input wire logic trip_pin,
   input wire logic pwm_demand,
   output mcr_pkg::mcr_leg_t gate_pins,
   output logic driver_shutdown,
   output logic bus_voltage_comp_enable,
   output logic current_offset_enable,
   output logic vector_loop_enable,
   output logic bus_monitor_enable,
   output logic fault_clear,
   output logic carrier_alignment_select,
   output logic [15:0] carrier_period_count,
   output logic [15:0] direct_axis_current_ref,
   output logic [15:0] quadrature_axis_current_ref,
   output logic [15:0] modulation_scale,
   output logic [15:0] velocity_scale,
   output logic irq
);

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   logic [15:0] count_wrap_limit;
   logic [15:0] index_preload_count;
   logic index_load_enable;
   logic count_enable;
   logic trip_input_polarity;
   logic low_side_gate_polarity;
   logic high_side_gate_polarity;
   logic shutdown_field;
   logic [7:0] dead_time_count;
   logic gate_output_enable;
   logic [2:0] irq_status;
   logic [2:0] irq_mask;
   logic [15:0] position_count;
   logic trip_latched;

   function automatic logic hit(input mcr_pkg::mcr_req_t r, input logic [4:0] off);
      hit = r.wr && (r.addr == off);
   endfunction : hit

   // host writes land on the next edge and hold until rewritten
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         count_wrap_limit <= `MCR_RESET_WORD;
         index_preload_count <= `MCR_RESET_WORD;
         index_load_enable <= 1'b0;
         count_enable <= 1'b0;
         trip_input_polarity <= 1'b0;
         low_side_gate_polarity <= 1'b0;
         high_side_gate_polarity <= 1'b0;
         shutdown_field <= 1'b0;
         carrier_alignment_select <= 1'b0;
         carrier_period_count <= `MCR_RESET_WORD;
         dead_time_count <= 8'h00;
         bus_voltage_comp_enable <= 1'b0;
         current_offset_enable <= 1'b0;
         vector_loop_enable <= 1'b0;
         gate_output_enable <= 1'b0;
         direct_axis_current_ref <= `MCR_RESET_WORD;
         quadrature_axis_current_ref <= `MCR_RESET_WORD;
         velocity_scale <= `MCR_RESET_WORD;
         modulation_scale <= `MCR_RESET_WORD;
         bus_monitor_enable <= 1'b0;
         irq_mask <= 3'h0;
      end
      else
      begin
         if (hit(req, `MCR_OFF_WRAP_LIMIT)) count_wrap_limit <= req.wdata;
         if (hit(req, `MCR_OFF_INDEX_PRELOAD)) index_preload_count <= req.wdata;
         if (hit(req, `MCR_OFF_ENC_CTRL))
         begin
            index_load_enable <= req.wdata[`MCR_ENC_INDEX_LOAD_BIT];
            count_enable <= req.wdata[`MCR_ENC_COUNT_ENABLE_BIT];
         end
         if (hit(req, `MCR_OFF_GATE_CFG))
         begin
            trip_input_polarity <= req.wdata[`MCR_GATE_TRIP_POL_BIT];
            low_side_gate_polarity <= req.wdata[`MCR_GATE_LOW_POL_BIT];
            high_side_gate_polarity <= req.wdata[`MCR_GATE_HIGH_POL_BIT];
            shutdown_field <= req.wdata[`MCR_GATE_SHUTDOWN_BIT];
            carrier_alignment_select <= req.wdata[`MCR_GATE_ALIGN_BIT];
         end
         if (hit(req, `MCR_OFF_CARRIER_PERIOD)) carrier_period_count <= req.wdata;
         if (hit(req, `MCR_OFF_DEAD_TIME)) dead_time_count <= req.wdata[7:0];
         if (hit(req, `MCR_OFF_SYS_CTRL))
         begin
            bus_voltage_comp_enable <= req.wdata[`MCR_SYS_BUS_COMP_BIT];
            current_offset_enable <= req.wdata[`MCR_SYS_OFFSET_BIT];
            vector_loop_enable <= req.wdata[`MCR_SYS_VECTOR_BIT];
            gate_output_enable <= req.wdata[`MCR_SYS_GATE_EN_BIT];
         end
         if (hit(req, `MCR_OFF_D_REF)) direct_axis_current_ref <= req.wdata;
         if (hit(req, `MCR_OFF_Q_REF)) quadrature_axis_current_ref <= req.wdata;
         if (hit(req, `MCR_OFF_VEL_SCALE)) velocity_scale <= req.wdata;
         if (hit(req, `MCR_OFF_MOD_SCALE)) modulation_scale <= req.wdata;
         if (hit(req, `MCR_OFF_FAULT_CTRL)) bus_monitor_enable <= req.wdata[`MCR_FLT_MONITOR_BIT];
         if (hit(req, `MCR_OFF_IRQ_MASK)) irq_mask <= req.wdata[2:0];
      end
   end

   // fault clear is a one-cycle strobe, not a stored level
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         fault_clear <= 1'b0;
      else
         fault_clear <= hit(req, `MCR_OFF_FAULT_CTRL) && req.wdata[`MCR_FLT_CLEAR_BIT];
   end

   // ----------------------------------------------------------------
   // position counter
   // ----------------------------------------------------------------
   logic wrap_event;
   logic index_event;
   assign wrap_event = count_enable && count_pulse && !count_down && (position_count == count_wrap_limit);
   assign index_event = index_pulse && index_load_enable;

   // index load beats counting; a host write beats both since it is an explicit set
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         position_count <= `MCR_RESET_WORD;
      else if (hit(req, `MCR_OFF_POS_WRITE))
         position_count <= req.wdata;
      else if (index_event)
         position_count <= index_preload_count;
      else if (count_enable && count_pulse)
      begin
         if (count_down)
            position_count <= (position_count == 16'h0000) ? count_wrap_limit : position_count - 16'h0001;
         else if (wrap_event)
            position_count <= 16'h0000;
         else
            position_count <= position_count + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // trip sensing and driver shutdown
   // ----------------------------------------------------------------
   logic trip_active;
   assign trip_active = trip_input_polarity ? trip_pin : !trip_pin;

   // trip holds the gates off until the host clears the fault
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         trip_latched <= 1'b0;
      else if (trip_active)
         trip_latched <= 1'b1;
      else if (fault_clear)
         trip_latched <= 1'b0;
   end

   // field value driven as-is: 0 holds the driver shut down
   // loaded beside the field so the pin never lags a write by an extra cycle
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         driver_shutdown <= 1'b0;
      else if (hit(req, `MCR_OFF_GATE_CFG))
         driver_shutdown <= req.wdata[`MCR_GATE_SHUTDOWN_BIT];
   end

   // ----------------------------------------------------------------
   // dead time insertion
   // ----------------------------------------------------------------
   localparam logic [7:0] TICK_CYCLES = 8'(`MCR_DEAD_TICK_CYCLES);
   mcr_pkg::mcr_dead_state_t dead_state;
   logic [7:0] tick_count;
   logic [7:0] dead_left;
   logic leg_target;
   logic allowed;
   assign allowed = gate_output_enable && !trip_latched;

   // on a demand change both gates go off for dead_time_count ticks first
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         dead_state <= mcr_pkg::MCR_LEG_OFF;
         tick_count <= 8'h00;
         dead_left <= 8'h00;
         leg_target <= 1'b0;
      end
      else
      begin
         unique case (dead_state)
            mcr_pkg::MCR_LEG_OFF:
               if (allowed)
               begin
                  dead_state <= mcr_pkg::MCR_LEG_DEAD;
                  leg_target <= pwm_demand;
                  dead_left <= dead_time_count;
                  tick_count <= 8'h00;
               end
            mcr_pkg::MCR_LEG_DEAD:
               if (!allowed)
                  dead_state <= mcr_pkg::MCR_LEG_OFF;
               else if (dead_left == 8'h00)
                  dead_state <= mcr_pkg::MCR_LEG_ON;
               else if (tick_count == TICK_CYCLES - 8'h01)
               begin
                  tick_count <= 8'h00;
                  dead_left <= dead_left - 8'h01;
               end
               else
                  tick_count <= tick_count + 8'h01;
            mcr_pkg::MCR_LEG_ON:
               if (!allowed)
                  dead_state <= mcr_pkg::MCR_LEG_OFF;
               else if (pwm_demand != leg_target)
               begin
                  dead_state <= mcr_pkg::MCR_LEG_DEAD;
                  leg_target <= pwm_demand;
                  dead_left <= dead_time_count;
                  tick_count <= 8'h00;
               end
         endcase
      end
   end

   // gates are driven inactive at their selected polarity outside the on state
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         gate_pins.high <= 1'b1;
         gate_pins.low <= 1'b1;
      end
      else
      begin
         gate_pins.high <= high_side_gate_polarity ~^ (dead_state == mcr_pkg::MCR_LEG_ON && leg_target);
         gate_pins.low <= low_side_gate_polarity ~^ (dead_state == mcr_pkg::MCR_LEG_ON && !leg_target);
      end
   end

   // ----------------------------------------------------------------
   // interrupts: sticky, write one to clear, set wins
   // ----------------------------------------------------------------
   logic [2:0] irq_events;
   logic [2:0] irq_clear;
   assign irq_events = {trip_active, index_event, wrap_event};
   assign irq_clear = hit(req, `MCR_OFF_IRQ_STATUS) ? req.wdata[2:0] : 3'h0;

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         irq_status <= 3'h0;
         irq <= 1'b0;
      end
      else
      begin
         irq_status <= (irq_status & ~irq_clear) | irq_events;
         irq <= |(((irq_status & ~irq_clear) | irq_events) & irq_mask);
      end
   end

   // ----------------------------------------------------------------
   // read port: data in the cycle after the strobe, unmapped reads zero
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         rdata <= `MCR_RESET_WORD;
      else if (req.rd)
      begin
         unique case (req.addr)
            `MCR_OFF_WRAP_LIMIT: rdata <= count_wrap_limit;
            `MCR_OFF_INDEX_PRELOAD: rdata <= index_preload_count;
            `MCR_OFF_ENC_CTRL: rdata <= {14'h0000, count_enable, index_load_enable};
            `MCR_OFF_GATE_CFG: rdata <= {11'h000, carrier_alignment_select, shutdown_field,
                                         high_side_gate_polarity, low_side_gate_polarity, trip_input_polarity};
            `MCR_OFF_CARRIER_PERIOD: rdata <= carrier_period_count;
            `MCR_OFF_DEAD_TIME: rdata <= {8'h00, dead_time_count};
            `MCR_OFF_SYS_CTRL: rdata <= {12'h000, gate_output_enable, vector_loop_enable,
                                         current_offset_enable, bus_voltage_comp_enable};
            `MCR_OFF_D_REF: rdata <= direct_axis_current_ref;
            `MCR_OFF_Q_REF: rdata <= quadrature_axis_current_ref;
            `MCR_OFF_VEL_SCALE: rdata <= velocity_scale;
            `MCR_OFF_MOD_SCALE: rdata <= modulation_scale;
            `MCR_OFF_FAULT_CTRL: rdata <= {14'h0000, bus_monitor_enable, 1'b0};
            `MCR_OFF_POS_COUNT: rdata <= position_count;
            `MCR_OFF_STATUS: rdata <= {13'h0000, trip_latched, dead_state == mcr_pkg::MCR_LEG_ON, trip_active};
            `MCR_OFF_IRQ_STATUS: rdata <= {13'h0000, irq_status};
            `MCR_OFF_IRQ_MASK: rdata <= {13'h0000, irq_mask};
            default: rdata <= 16'h0000;
         endcase
      end
      else
         rdata <= 16'h0000;
   end

endmodule : mcr_regs

// ---- verif/mcr_regs_chk.sv ----
// port checker for the motor control register bank
`timescale 1ns/100ps
`include "mcr_params.svh"
module mcr_regs_chk
(
   input wire logic clk,
   input wire logic reset_n,
   input wire mcr_pkg::mcr_req_t req,
   input wire logic [15:0] rdata,
   input wire mcr_pkg::mcr_leg_t gate_pins,
   input wire logic driver_shutdown,
   input wire logic bus_voltage_comp_enable,
   input wire logic current_offset_enable,
   input wire logic vector_loop_enable,
   input wire logic bus_monitor_enable,
   input wire logic fault_clear,
   input wire logic [15:0] direct_axis_current_ref
);
   // ----------------------------------------------------------------
   // shadow of gate enable and polarity
   // ----------------------------------------------------------------
   logic armed;
   logic [1:0] pol;
   logic [2:0] quiet;

   // the gate path is pipelined, so idle levels are judged only once quiet saturates
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         armed <= 1'b0;
         pol <= 2'b00;
         quiet <= 3'h0;
      end
      else if (req.wr && req.addr == `MCR_OFF_GATE_CFG)
      begin
         pol <= req.wdata[2:1];
         quiet <= 3'h0;
      end
      else
      begin
         armed <= armed | (req.wr && req.addr == `MCR_OFF_SYS_CTRL && req.wdata[3]);
         if (quiet != 3'h7)
            quiet <= quiet + 3'h1;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_vector_write:
      assert property (req.wr && req.addr == `MCR_OFF_SYS_CTRL |=> vector_loop_enable == $past(req.wdata[2]))
      else $error("vector enable differs from written bit");
   a_comp_offset:
      assert property (req.wr && req.addr == `MCR_OFF_SYS_CTRL
         |=> {current_offset_enable, bus_voltage_comp_enable} == $past(req.wdata[1:0]))
      else $error("compensation enables differ from written bits");
   a_monitor_write:
      assert property (req.wr && req.addr == `MCR_OFF_FAULT_CTRL |=> bus_monitor_enable == $past(req.wdata[1]))
      else $error("bus monitor enable differs from written bit");
   a_shutdown_copy:
      assert property (req.wr && req.addr == `MCR_OFF_GATE_CFG |=> driver_shutdown == $past(req.wdata[3]))
      else $error("shutdown output differs from field");
   a_dref_write:
      assert property (req.wr && req.addr == `MCR_OFF_D_REF |=> direct_axis_current_ref == $past(req.wdata))
      else $error("direct reference differs from written word");
   a_field_hold:
      assert property (!(req.wr && req.addr == `MCR_OFF_SYS_CTRL) |=> $stable(vector_loop_enable))
      else $error("vector enable moved without a write");
   a_gates_idle:
      assert property (!armed && quiet == 3'h7 |-> {gate_pins.high, gate_pins.low} == ~pol)
      else $error("gate active before output enable");
   a_rdata_idle:
      assert property (!req.rd |=> rdata == 16'h0000)
      else $error("read data outside the read answer cycle");
   a_fault_pulse:
      assert property (fault_clear |-> $past(req.wr) && $past(req.addr) == `MCR_OFF_FAULT_CTRL && $past(req.wdata[0]))
      else $error("fault clear pulse without a clear write");
endmodule : mcr_regs_chk

bind mcr_regs mcr_regs_chk chk
(
   .clk(clk), .reset_n(reset_n), .req(req), .rdata(rdata), .gate_pins(gate_pins),
   .driver_shutdown(driver_shutdown), .bus_voltage_comp_enable(bus_voltage_comp_enable),
   .current_offset_enable(current_offset_enable), .vector_loop_enable(vector_loop_enable),
   .bus_monitor_enable(bus_monitor_enable), .fault_clear(fault_clear),
   .direct_axis_current_ref(direct_axis_current_ref)
);

// ---- verif/mcr_host_model.sv ----
// host processor model driving the register port of the control bank
`timescale 1ns/100ps
`include "mcr_params.svh"
module mcr_host_model
(
   input wire logic clk,
   input wire logic [15:0] rdata,
   output mcr_pkg::mcr_req_t req
);
   initial
      req = '0;

   // a released bus shows the inverse of the last word, so stale values never look valid
   task automatic write_word(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
   endtask : write_word

   // the answer stands only in the cycle after the strobe
   task automatic read_word(input logic [4:0] a, output logic [15:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: req.wdata, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req <= '{addr: ~a, wdata: req.wdata, wr: 1'b0, rd: 1'b0};
      #1;
      d = rdata;
   endtask : read_word

   // scaling words are written last, after the gates have been started; truncation loses under one lsb
   task automatic configure(input int period, input int lines, input int rpm);
      real m;
      real v;
      m = period * 1.7320508075688772 * 4096.0 / 2355.0;
      v = 60.0 * 16383.0 * 33.333 / 32.0 * 1.0e6 / (lines * rpm);
      write_word(`MCR_OFF_CARRIER_PERIOD, period[15:0]);
      write_word(`MCR_OFF_MOD_SCALE, 16'($rtoi(m)));
      write_word(`MCR_OFF_VEL_SCALE, 16'($rtoi(v)));
   endtask : configure
endmodule : mcr_host_model

// ---- verif/mcr_regs_bench.sv ----
// self-checking bench for the motor control register bank
`timescale 1ns/100ps
`include "mcr_params.svh"
module mcr_regs_bench;
   logic clk;
   logic reset_n;
   mcr_pkg::mcr_req_t req;
   logic [15:0] rdata;
   logic cnt, down, idx, trip, demand;
   mcr_pkg::mcr_leg_t gp;
   logic shut, comp, offs_en, vec, mon, fclr, align, irq;
   logic [15:0] period, dref, qref, mods, vels, got;
   int failures;
   int checks;
   int cycles = 0;
   int dead;
   int n;
   logic [4:0] offs [7];

   mcr_regs DUT
   (
      .clk(clk), .reset_n(reset_n), .req(req), .rdata(rdata), .count_pulse(cnt), .count_down(down),
      .index_pulse(idx), .trip_pin(trip), .pwm_demand(demand), .gate_pins(gp), .driver_shutdown(shut),
      .bus_voltage_comp_enable(comp), .current_offset_enable(offs_en), .vector_loop_enable(vec),
      .bus_monitor_enable(mon), .fault_clear(fclr), .carrier_alignment_select(align),
      .carrier_period_count(period), .direct_axis_current_ref(dref), .quadrature_axis_current_ref(qref),
      .modulation_scale(mods), .velocity_scale(vels), .irq(irq)
   );

   mcr_host_model host
   (
      .clk(clk),
      .rdata(rdata),
      .req(req)
   );

   // ----------------------------------------------------------------
   // clock, hang guard and helpers
   // ----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // the whole run needs well under a thousand cycles
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 4000)
      begin
         failures = failures + 1;
         wrap_up();
      end
   end

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
      checks = checks + 1;
      if (seen !== exp)
      begin
         failures = failures + 1;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp, input string what);
      host.read_word(a, got);
      check(what, exp, got);
   endtask : rd_chk

   // let registered outputs land before looking at them
   task automatic settle(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : settle

   task automatic wrap_up;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial
   begin
      reset_n = 1'b0;
      {cnt, down, idx, demand} = 4'h0;
      trip = 1'b1;
      failures = 0;
      checks = 0;
      offs = '{5'h01, 5'h02, 5'h05, 5'h08, 5'h09, 5'h0A, 5'h0B};
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      settle(1);
      check("gates", 16'h0003, {14'h0000, gp});
      check("vector", 16'h0000, {15'h0000, vec});
      for (n = 1; n < 13; n++)
         rd_chk(n[4:0], 16'h0000, "reset word");
      $display("test reset done");
      for (n = 0; n < 7; n++)
         host.write_word(offs[n], 16'h5A00 + n[15:0]);
      for (n = 0; n < 7; n++)
         rd_chk(offs[n], 16'h5A00 + n[15:0], "control word");
      check("q ref", 16'h5A04, qref);
      host.write_word(`MCR_OFF_SYS_CTRL, 16'h0007);
      host.write_word(`MCR_OFF_FAULT_CTRL, 16'h0003);
      #1;
      check("fault clear", 16'h0001, {15'h0000, fclr});
      settle(1);
      check("fault clear end", 16'h0000, {15'h0000, fclr});
      check("enables", 16'h000F, {12'h000, mon, vec, offs_en, comp});
      host.write_word(`MCR_OFF_POS_COUNT, 16'hFFFF);
      rd_chk(`MCR_OFF_POS_COUNT, 16'h0000, "read only");
      rd_chk(`MCR_OFF_FAULT_CTRL, 16'h0002, "fault word");
      rd_chk(5'h1F, 16'h0000, "unmapped");
      host.write_word(`MCR_OFF_GATE_CFG, 16'h0010);
      settle(1);
      check("alignment", 16'h0001, {15'h0000, align});
      rd_chk(`MCR_OFF_GATE_CFG, 16'h0010, "gate word");
      $display("test access done");
      host.write_word(`MCR_OFF_WRAP_LIMIT, 16'h0005);
      host.write_word(`MCR_OFF_ENC_CTRL, 16'h0002);
      host.write_word(`MCR_OFF_POS_WRITE, 16'h0004);
      cnt <= 1'b1;
      settle(2);
      cnt <= 1'b0;
      rd_chk(`MCR_OFF_POS_COUNT, 16'h0000, "wrap up");
      {cnt, down} <= 2'b11;
      settle(1);
      {cnt, down} <= 2'b00;
      rd_chk(`MCR_OFF_POS_COUNT, 16'h0005, "wrap down");
      host.write_word(`MCR_OFF_INDEX_PRELOAD, 16'h0003);
      host.write_word(`MCR_OFF_ENC_CTRL, 16'h0001);
      idx <= 1'b1;
      settle(1);
      idx <= 1'b0;
      rd_chk(`MCR_OFF_POS_COUNT, 16'h0003, "index load");
      host.write_word(`MCR_OFF_ENC_CTRL, 16'h0000);
      host.write_word(`MCR_OFF_POS_WRITE, 16'h0002);
      idx <= 1'b1;
      settle(1);
      idx <= 1'b0;
      rd_chk(`MCR_OFF_POS_COUNT, 16'h0002, "index off");
      rd_chk(`MCR_OFF_IRQ_STATUS, 16'h0003, "event flags");
      check("irq masked", 16'h0000, {15'h0000, irq});
      host.write_word(`MCR_OFF_IRQ_MASK, 16'h0001);
      settle(1);
      check("irq set", 16'h0001, {15'h0000, irq});
      host.write_word(`MCR_OFF_IRQ_STATUS, 16'h0007);
      settle(1);
      check("irq clear", 16'h0000, {15'h0000, irq});
      $display("test counter done");
      host.write_word(`MCR_OFF_DEAD_TIME, 16'h0002);
      host.write_word(`MCR_OFF_GATE_CFG, 16'h0008);
      settle(4);
      check("shutdown", 16'h0001, {15'h0000, shut});
      check("gates held", 16'h0003, {14'h0000, gp});
      host.write_word(`MCR_OFF_SYS_CTRL, 16'h000F);
      settle(20);
      check("low on", 16'h0002, {14'h0000, gp});
      demand <= 1'b1;
      dead = 0;
      for (n = 0; n < 40 && gp !== 2'b01; n++)
      begin
         settle(1);
         if (gp === 2'b11)
            dead++;
      end
      check("high on", 16'h0001, {14'h0000, gp});
      check("dead span", 16'h0001, {15'h0000, dead >= 6 && dead <= 8});
      host.write_word(`MCR_OFF_GATE_CFG, 16'h000E);
      settle(12);
      check("active high", 16'h0002, {14'h0000, gp});
      host.write_word(`MCR_OFF_GATE_CFG, 16'h0008);
      trip <= 1'b0;
      settle(2);
      trip <= 1'b1;
      settle(3);
      check("tripped", 16'h0003, {14'h0000, gp});
      rd_chk(`MCR_OFF_STATUS, 16'h0004, "status tripped");
      rd_chk(`MCR_OFF_IRQ_STATUS, 16'h0004, "trip flag");
      host.write_word(`MCR_OFF_FAULT_CTRL, 16'h0003);
      settle(20);
      check("restart", 16'h0001, {14'h0000, gp});
      rd_chk(`MCR_OFF_STATUS, 16'h0002, "status running");
      $display("test gates done");
      host.configure(1666, 8000, 3000);
      settle(1);
      check("period", 16'h0682, period);
      check("mod scale", 16'h139A, mods);
      check("vel scale", 16'hA6A7, vels);
      reset_n <= 1'b0;
      settle(2);
      reset_n <= 1'b1;
      settle(1);
      check("vector", 16'h0000, {15'h0000, vec});
      check("gates", 16'h0003, {14'h0000, gp});
      $display("test scaling and reset done");
      wrap_up();
   end
endmodule : mcr_regs_bench
